// [hdl/tiopc_pkg.sv]
// Constants for the timed I/O port block: register map, control fields and pin roles.
// Assumes one 100 MHz reference clock that is also the tile reference clock.
package tiopc_pkg;
  localparam int NUM_PINS = 4;
  localparam int WIDE_W = 4;
  localparam int NUM_CB = 6;
  localparam int CB_VEC_W = 8;
  localparam int CNT_W = 16;
  localparam int CB_SEL_W = 3;
  localparam int DIV_W = 8;
  localparam int CB_CFG_W = 9;
  localparam int CTRL_W = 10;
  localparam int OFF_W = 5;
  // Register pages, selected by address bits 7:5.
  localparam logic [2:0] PAGE_A = 3'h0;
  localparam logic [2:0] PAGE_B = 3'h1;
  localparam logic [2:0] PAGE_C = 3'h2;
  localparam logic [2:0] PAGE_CB = 3'h4;
  localparam logic [2:0] CB_LAST = 3'h5;
  // Register offsets inside a port page.
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_DATA = 5'h04;
  localparam logic [4:0] OFF_TIME = 5'h08;
  localparam logic [4:0] OFF_TSTAMP = 5'h0c;
  localparam logic [4:0] OFF_COND = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h14;
  localparam logic [4:0] OFF_MASK = 5'h1c;
  // Port control fields.
  localparam int CTL_EN = 0;
  localparam int CTL_DIR = 1;
  localparam int CTL_OC = 2;
  localparam int CTL_CLK_LSB = 3;
  localparam int CTL_COND_LSB = 6;
  localparam int CTL_SIN = 8;
  localparam int CTL_SOUT = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
  // Clock block fields.
  localparam int CB_SRC = 8;
  localparam logic [CB_CFG_W-1:0] CB_RESET = 9'h000;
  // Pin roles.
  localparam int PIN_B = 0;
  localparam int PIN_C = 1;
  localparam int PIN_LTX = 2;
  localparam int PIN_LRX = 3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NEQ} tiopc_cond_type;
  typedef enum logic [1:0] {BUS_IDLE, BUS_RD_WAIT, BUS_RD_DONE} tiopc_bus_type;
endpackage

// [hdl/tiopc_top.sv]
// Timed I/O ports with clock blocks behind an AHB-Lite slave.
// Assumes pins are sampled synchronously to ref_clk, which is the tile reference clock.
// What this block does
// - One direction for all pins of a port.
// - Open collector: zero pulls low, one floats.
// - Port writes complete in one cycle; reads add one wait cycle.
// - Data passes shift stage and transfer register.
// - Each port has a 16-bit counter.
// - Counter readable; transfers delayable to counter value.
// - Transfer stores counter as timestamp.
// - Enabled link removes ports from shared pins.
// - Narrower enabled port wins shared pins.
// - Unshared pins stay with wider port.
// - Port transfers always at full width.
// - Six clock blocks per tile, five of them programmable.
// - Clock block 0 is 100 MHz reference.
// - Other clock blocks run at own rates.
// - Clock block may take one-pin port clock.
// - External clock source optionally divided.
// - The wide port accepts and produces strobes.
// - Drive pins or sample, optionally awaiting condition.
// - After reset ports use clock block 0.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps

module tiopc_cb
  import tiopc_pkg::*;
#(
  parameter bit FIXED_REF = 1'b0
)
(
  input wire logic ref_clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic wr_en, // Configuration write strobe.
  input wire logic [CB_CFG_W-1:0] wdata, // Configuration write data.
  input wire logic ext_clk, // Level of the one-pin clock port.
  output logic [CB_CFG_W-1:0] cfg, // Current configuration.
  output logic tick // One-cycle tick of this clock block.
);
  logic [CB_CFG_W-1:0] cfg_reg;
  logic ext_prev_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  logic evt;

  // An external edge or every reference cycle, then divided by div+1.
  assign evt = cfg_reg[CB_SRC] ? (ext_clk & ~ext_prev_reg) : 1'b1;
  // Block 0 is the reference itself, so it ticks on every cycle of ref_clk.
  assign tick = FIXED_REF ? 1'b1 : (evt && div_cnt_reg == cfg_reg[DIV_W-1:0]);
  assign cfg = cfg_reg;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cfg_reg <= CB_RESET;
    else if (wr_en && !FIXED_REF)
      cfg_reg <= wdata;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      ext_prev_reg <= 1'b0;
    else
      ext_prev_reg <= ext_clk;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      div_cnt_reg <= '0;
    else if (wr_en || tick)
      div_cnt_reg <= '0;
    else if (evt)
      div_cnt_reg <= div_cnt_reg + 8'h01;
  end
endmodule

module tiopc_port
  import tiopc_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic ref_clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [CB_VEC_W-1:0] cb_tick, // Ticks of all clock blocks.
  input wire logic wr_en, // Register write strobe.
  input wire logic rd_en, // Register read strobe, one cycle.
  input wire logic [OFF_W-1:0] acc_off, // Register offset within the page.
  input wire logic [31:0] wdata, // Write data.
  output logic [31:0] rdata, // Read data for acc_off.
  input wire logic [W-1:0] pin_in, // Sampled pin levels.
  output logic [W-1:0] pin_out, // Pin drive levels.
  output logic [W-1:0] pin_oe, // Pin drive enables.
  input wire logic strobe_in, // Incoming strobe.
  output logic strobe_out, // Outgoing strobe.
  output logic port_en // Port enabled.
);
  logic [CTRL_W-1:0] ctrl_reg;
  logic [W-1:0] xfer_reg;
  logic [W-1:0] shift_reg;
  logic [W-1:0] cond_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] time_reg;
  logic [CNT_W-1:0] tstamp_reg;
  logic timed_reg;
  logic valid_reg;
  logic strobe_reg;
  logic [CB_SEL_W-1:0] clk_sel;
  logic tick;
  logic dir_out;
  logic time_ok;
  logic cond_ok;
  logic fire;
  logic wr_ctrl;
  logic wr_data;
  logic wr_time;
  tiopc_cond_type cond_mode;

  assign clk_sel = ctrl_reg[CTL_CLK_LSB +: CB_SEL_W];
  assign tick = cb_tick[clk_sel];
  assign dir_out = ctrl_reg[CTL_DIR];
  assign port_en = ctrl_reg[CTL_EN];
  assign cond_mode = tiopc_cond_type'(ctrl_reg[CTL_COND_LSB +: 2]);
  assign wr_ctrl = wr_en && acc_off == OFF_CTRL;
  assign wr_data = wr_en && acc_off == OFF_DATA;
  assign wr_time = wr_en && acc_off == OFF_TIME;
  assign time_ok = !timed_reg || cnt_reg == time_reg;

  always_comb
  begin
    unique case (cond_mode)
      COND_NONE: cond_ok = 1'b1;
      COND_EQ: cond_ok = shift_reg == cond_reg;
      COND_NEQ: cond_ok = shift_reg != cond_reg;
      default: cond_ok = 1'b1;
    endcase
  end

  // A transfer waits for its tick, its time, the incoming strobe and, for input, the condition.
  assign fire = port_en && tick && time_ok && (!ctrl_reg[CTL_SIN] || strobe_in)
    && (dir_out ? valid_reg : (!valid_reg && cond_ok));

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      ctrl_reg <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl_reg <= wdata[CTRL_W-1:0];
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cond_reg <= '0;
    else if (wr_en && acc_off == OFF_COND)
      cond_reg <= wdata[W-1:0];
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_reg <= '0;
    else if (tick)
      cnt_reg <= cnt_reg + 16'h0001;
  end

  // The shift stage faces the pins; the transfer register faces software.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      shift_reg <= '0;
    else if (dir_out && fire)
      shift_reg <= xfer_reg;
    // Turning to input drops the last output word; an output transfer firing in that same cycle still leaves its word to be taken as a sample.
    else if (wr_ctrl && !wdata[CTL_DIR])
      shift_reg <= pin_in;
    else if (!dir_out && tick)
      shift_reg <= pin_in;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      xfer_reg <= '0;
    else if (dir_out && wr_data)
      xfer_reg <= wdata[W-1:0];
    else if (!dir_out && fire)
      xfer_reg <= shift_reg;
  end

  // Set wins over the transfer and read clears, so a write in the cycle of a transfer is kept.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      valid_reg <= 1'b0;
    else if (wr_ctrl)
      valid_reg <= 1'b0;
    else if ((dir_out && wr_data) || (!dir_out && fire))
      valid_reg <= 1'b1;
    else if ((dir_out && fire) || (!dir_out && rd_en && acc_off == OFF_DATA))
      valid_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      timed_reg <= 1'b0;
    else if (wr_time)
      timed_reg <= 1'b1;
    else if (fire || wr_ctrl)
      timed_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      time_reg <= '0;
    else if (wr_time)
      time_reg <= wdata[CNT_W-1:0];
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      tstamp_reg <= '0;
    else if (fire)
      tstamp_reg <= cnt_reg;
  end

  // The strobe covers one tick period of freshly output data.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      strobe_reg <= 1'b0;
    else if (dir_out && fire)
      strobe_reg <= ctrl_reg[CTL_SOUT];
    else if (tick)
      strobe_reg <= 1'b0;
  end

  assign strobe_out = strobe_reg;
  // Open collector drives only zeros; the whole port shares one direction.
  assign pin_oe = (port_en && dir_out) ? (ctrl_reg[CTL_OC] ? ~shift_reg : '1) : '0;
  assign pin_out = ctrl_reg[CTL_OC] ? '0 : shift_reg;

  always_comb
  begin
    rdata = 32'h0000_0000;
    unique case (acc_off)
      OFF_CTRL: rdata[CTRL_W-1:0] = ctrl_reg;
      OFF_DATA: rdata[W-1:0] = xfer_reg;
      OFF_TIME: rdata[CNT_W-1:0] = cnt_reg;
      OFF_TSTAMP: rdata[CNT_W-1:0] = tstamp_reg;
      OFF_COND: rdata[W-1:0] = cond_reg;
      OFF_STATUS: rdata[1:0] = {timed_reg, valid_reg};
      default: rdata = 32'h0000_0000;
    endcase
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence out_fire_s;
    dir_out && fire;
  endsequence

  sequence out_shown_s;
    shift_reg == $past(xfer_reg) && tstamp_reg == $past(cnt_reg);
  endsequence

  cnt_step_a: assert property (tick |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("port counter did not step on its tick");
  cnt_hold_a: assert property (!tick |=> $stable(cnt_reg))
    else $error("port counter moved without a tick");
  out_xfer_a: assert property (out_fire_s |=> out_shown_s)
    else $error("output transfer did not reach the pins with its timestamp");
  timed_hold_a: assert property (dir_out && valid_reg && timed_reg && cnt_reg != time_reg
    && !wr_ctrl |=> valid_reg)
    else $error("timed output left before its time");
  oc_float_a: assert property (ctrl_reg[CTL_OC] |-> (pin_out == '0))
    else $error("open collector pin driven high");
  in_quiet_a: assert property (!dir_out |-> pin_oe == '0)
    else $error("input port drives a pin");
  strobe_out_a: assert property (out_fire_s ##0 ctrl_reg[CTL_SOUT] |=> strobe_out)
    else $error("no strobe with output data");
  cond_wait_a: assert property (!dir_out && !valid_reg && !cond_ok && !wr_en |=> !valid_reg)
    else $error("input captured while condition false");
endmodule

module tiopc_top
  import tiopc_pkg::*;
(
  input wire logic ref_clk, // 100 MHz reference clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write.
  input wire logic [2:0] hsize, // AHB size, word only.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic [31:0] hrdata, // AHB read data.
  output logic hreadyout, // AHB slave ready.
  output logic hresp, // AHB response, always OKAY.
  input wire logic [NUM_PINS-1:0] pin_in, // Pin levels.
  output logic [NUM_PINS-1:0] pin_out, // Pin drive levels.
  output logic [NUM_PINS-1:0] pin_oe, // Pin drive enables.
  input wire logic link_en, // Link owns its pins.
  input wire logic link_tx, // Link transmit level.
  output logic link_rx, // Link receive level.
  input wire logic strobe_input, // Incoming strobe of the wide port.
  output logic strobe_output // Outgoing strobe of the wide port.
);
  tiopc_bus_type bus_reg;
  logic [7:0] addr_reg;
  logic hit_reg;
  logic wr_pend_reg;
  logic [31:0] hrdata_reg;
  logic take;
  logic wr_now;
  logic rd_now;
  logic [2:0] page;
  logic [OFF_W-1:0] off;
  logic [CB_SEL_W-1:0] cb_idx;
  logic [CB_VEC_W-1:0] cb_tick;
  logic [CB_CFG_W-1:0] cb_cfg [NUM_CB];
  logic [31:0] a_rdata;
  logic [31:0] b_rdata;
  logic [31:0] c_rdata;
  logic [31:0] rd_mux;
  logic [WIDE_W-1:0] a_out;
  logic [WIDE_W-1:0] a_oe;
  logic b_out;
  logic b_oe;
  logic c_out;
  logic c_oe;
  logic a_en;
  logic b_en;
  logic c_en;

  assign take = hsel && hready && htrans == HTRANS_NONSEQ;
  assign page = addr_reg[7:5];
  assign off = addr_reg[4:0] & OFF_MASK;
  assign cb_idx = addr_reg[4:2];
  assign wr_now = wr_pend_reg && hit_reg;
  assign rd_now = bus_reg == BUS_RD_WAIT && hit_reg;
  assign hreadyout = bus_reg != BUS_RD_WAIT;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_reg;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_reg <= 8'h00;
      hit_reg <= 1'b0;
    end
    else if (take)
    begin
      addr_reg <= haddr[7:0];
      hit_reg <= haddr[31:8] == 24'h00_0000;
    end
  end

  // Writes finish in their one data-phase cycle; reads add one wait for registered data.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      wr_pend_reg <= 1'b0;
    else
      wr_pend_reg <= take && hwrite;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      bus_reg <= BUS_IDLE;
    else
      unique case (bus_reg)
        BUS_RD_WAIT: bus_reg <= BUS_RD_DONE;
        BUS_IDLE, BUS_RD_DONE: bus_reg <= (take && !hwrite) ? BUS_RD_WAIT : BUS_IDLE;
        default: bus_reg <= BUS_IDLE;
      endcase
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_reg)
      unique case (page)
        PAGE_A: rd_mux = a_rdata;
        PAGE_B: rd_mux = b_rdata;
        PAGE_C: rd_mux = c_rdata;
        PAGE_CB:
          if (cb_idx <= CB_LAST)
            rd_mux[CB_CFG_W-1:0] = cb_cfg[cb_idx];
        default: rd_mux = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      hrdata_reg <= 32'h0000_0000;
    else if (bus_reg == BUS_RD_WAIT)
      hrdata_reg <= rd_mux;
  end

  assign cb_tick[CB_VEC_W-1:NUM_CB] = '0;

  for (genvar i = 0; i < NUM_CB; i++)
  begin : g_cb
    tiopc_cb #(.FIXED_REF(i == 0)) u_cb (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .wr_en(wr_now && page == PAGE_CB && cb_idx == 3'(i)),
      .wdata(hwdata[CB_CFG_W-1:0]),
      .ext_clk(pin_in[PIN_C]),
      .cfg(cb_cfg[i]),
      .tick(cb_tick[i])
    );
  end

  tiopc_port #(.W(WIDE_W)) u_port_a (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cb_tick(cb_tick),
    .wr_en(wr_now && page == PAGE_A),
    .rd_en(rd_now && page == PAGE_A),
    .acc_off(off),
    .wdata(hwdata),
    .rdata(a_rdata),
    .pin_in(pin_in),
    .pin_out(a_out),
    .pin_oe(a_oe),
    .strobe_in(strobe_input),
    .strobe_out(strobe_output),
    .port_en(a_en)
  );

  tiopc_port #(.W(1)) u_port_b (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cb_tick(cb_tick),
    .wr_en(wr_now && page == PAGE_B),
    .rd_en(rd_now && page == PAGE_B),
    .acc_off(off),
    .wdata(hwdata),
    .rdata(b_rdata),
    .pin_in(pin_in[PIN_B]),
    .pin_out(b_out),
    .pin_oe(b_oe),
    .strobe_in(1'b0),
    .strobe_out(),
    .port_en(b_en)
  );

  tiopc_port #(.W(1)) u_port_c (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cb_tick(cb_tick),
    .wr_en(wr_now && page == PAGE_C),
    .rd_en(rd_now && page == PAGE_C),
    .acc_off(off),
    .wdata(hwdata),
    .rdata(c_rdata),
    .pin_in(pin_in[PIN_C]),
    .pin_out(c_out),
    .pin_oe(c_oe),
    .strobe_in(1'b0),
    .strobe_out(),
    .port_en(c_en)
  );

  // The wide port still moves four bits; bits on lost pins simply do not reach them.
  always_comb
  begin
    pin_out = a_out;
    pin_oe = a_oe & {WIDE_W{a_en}};
    if (b_en)
    begin
      pin_out[PIN_B] = b_out;
      pin_oe[PIN_B] = b_oe;
    end
    if (c_en)
    begin
      pin_out[PIN_C] = c_out;
      pin_oe[PIN_C] = c_oe;
    end
    if (link_en)
    begin
      pin_out[PIN_LTX] = link_tx;
      pin_oe[PIN_LTX] = 1'b1;
      pin_out[PIN_LRX] = 1'b0;
      pin_oe[PIN_LRX] = 1'b0;
    end
  end

  assign link_rx = pin_in[PIN_LRX];

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  link_pins_a: assert property (link_en |-> pin_oe[PIN_LTX] && pin_out[PIN_LTX] == link_tx
    && !pin_oe[PIN_LRX])
    else $error("port drives a pin owned by the link");
  narrow_win_a: assert property (b_en |-> pin_oe[PIN_B] == b_oe && pin_out[PIN_B] == b_out)
    else $error("narrow port lost its shared pin");
  wide_keep_a: assert property (a_en && !link_en |-> pin_oe[3:2] == a_oe[3:2])
    else $error("wide port lost an unshared pin");
  ref_tick_a: assert property (cb_tick[0])
    else $error("reference clock block missed a cycle");
  wr_ready_a: assert property (wr_pend_reg |-> hreadyout)
    else $error("write data phase stalled");
  rd_timing_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer not after one wait cycle");
endmodule

// [sim/tiopc_pin_model.sv]
// Pin-side partner: pull-ups on every pin, application drivers and a strobe source.
// Assumes the bench moves app_oe, app_val and strobe_req just after ref_clk rises.
`timescale 1ns/100ps
module tiopc_pin_model
  import tiopc_pkg::*;
(
  input wire logic ref_clk, // System clock.
  input wire logic [NUM_PINS-1:0] pin_out, // Device drive levels.
  input wire logic [NUM_PINS-1:0] pin_oe, // Device drive enables.
  input wire logic [NUM_PINS-1:0] app_oe, // Application drive enables.
  input wire logic [NUM_PINS-1:0] app_val, // Application drive levels.
  input wire logic strobe_req, // Application wants to raise its strobe.
  input wire logic [3:0] strobe_lag, // Cycles before the strobe shows.
  output logic [NUM_PINS-1:0] pin_in, // Resolved pin levels.
  output logic strobe_input // Strobe seen by the device.
);
  logic [3:0] lag_reg;
  // A released pin floats up, which an open collector output relies on.
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
    begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (app_oe[i] ? app_val[i] : 1'b1);
    end
  end
  // A slow source shows its strobe only after strobe_lag cycles.
  always_ff @(posedge ref_clk)
  begin
    lag_reg <= !strobe_req ? strobe_lag : (lag_reg == 4'h0 ? 4'h0 : lag_reg - 4'h1);
  end
  assign strobe_input = strobe_req && lag_reg == 4'h0;
endmodule

// [sim/tiopc_top_tb.sv]
// Self-checking bench for the timed I/O ports and clock blocks, with a pin model.
// Assumes the AHB-Lite slave is alone on the bus and ref_clk runs at 100 MHz.
`timescale 1ns/100ps
module tiopc_top_tb
  import tiopc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, c0, r;
  logic hreadyout, hresp, link_rx, strobe_input, strobe_output;
  logic link_en = 1'b0;
  logic link_tx = 1'b0;
  logic strobe_req = 1'b0;
  logic [3:0] strobe_lag = 4'h0;
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe;
  logic [NUM_PINS-1:0] app_oe = 4'h0;
  logic [NUM_PINS-1:0] app_val = 4'h0;
  int bad_count = 0;
  int checks_done = 0;
  int d, t, n;
  always #5 ref_clk = ~ref_clk;
  tiopc_top tiopc_top_inst (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .link_en(link_en), .link_tx(link_tx),
    .link_rx(link_rx), .strobe_input(strobe_input), .strobe_output(strobe_output));
  tiopc_pin_model tiopc_pin_model_inst (.ref_clk(ref_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .app_oe(app_oe), .app_val(app_val), .strobe_req(strobe_req),
    .strobe_lag(strobe_lag), .pin_in(pin_in), .strobe_input(strobe_input));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_up();
    bad_count++;
    tally_and_finish();
  endtask
  // Ready and read data are looked at mid-cycle, where they have settled.
  task automatic edge_ready(output int w, output logic [31:0] v);
    logic s;
    w = 0;
    do
    begin
      @(negedge ref_clk);
      s = hreadyout;
      v = hrdata;
      @(posedge ref_clk);
      w += (s !== 1'b1) ? 1 : 0;
      if (w > 40)
        give_up();
    end
    while (s !== 1'b1);
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] v);
    int w;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    edge_ready(w, v);
    htrans <= 2'h0;
    hwdata <= wd;
    edge_ready(w, v);
    chk("wait states", 32'(w), wr ? 32'h0 : 32'h1);
    chk("response", 32'(hresp), 32'(HRESP_OKAY));
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h0, v);
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(nm, v, exp);
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // Reads a status word until the masked bits match, within a bounded number of reads.
  task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] want);
    logic [31:0] v;
    int k;
    k = 0;
    do
    begin
      rd(a, v);
      k++;
      if (k > 200)
        give_up();
    end
    while ((v & m) !== want);
  endtask
  function automatic logic [31:0] pa(input logic [2:0] pg, input logic [4:0] off);
    return {24'h0, pg, off};
  endfunction
  function automatic logic [31:0] ctl(input int en, dir, oc, sel, cnd, sin, sout);
    return 32'((en << CTL_EN) | (dir << CTL_DIR) | (oc << CTL_OC) | (sel << CTL_CLK_LSB)
      | (cnd << CTL_COND_LSB) | (sin << CTL_SIN) | (sout << CTL_SOUT));
  endfunction
  function automatic logic [31:0] ticks(input logic [31:0] a, input logic [31:0] b);
    return {16'h0, b[15:0] - a[15:0]};
  endfunction
  function automatic logic cond_ok(input int c, input int lvl);
    return c == 0 || (c == 1 && lvl == 1) || (c == 2 && lvl == 0);
  endfunction
  initial
  begin
    void'($urandom(80));
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    chk("reset oe", 32'(pin_oe), 32'h0);
    chk("reset strobe", 32'(strobe_output), 32'h0);
    @(posedge ref_clk);
    for (int p = 0; p < 3; p++)
      rdc("reset ctrl", pa(3'(p), OFF_CTRL), 32'(CTRL_RESET));
    wr(32'h80, 32'h1ff);
    rdc("block zero", 32'h80, 32'h0);
    for (int i = 0; i < 4; i++)
      begin
        t = (i == 0) ? 32'h98 : (i == 1) ? 32'h9c : (i == 2) ? 32'h100 : 32'h18;
        wr(32'(t), 32'h5a);
        rdc("unmapped", 32'(t), 32'h0);
      end
    for (int i = 1; i < NUM_CB; i++)
    begin
      d = $urandom_range(3, 0);
      wr(32'h80 + 32'(4 * i), 32'(d));
      rdc("block cfg", 32'h80 + 32'(4 * i), 32'(d));
      wr(pa(PAGE_A, OFF_CTRL), ctl(1, 0, 0, i, 0, 0, 0));
      rd(pa(PAGE_A, OFF_TIME), c0);
      idle(4 * (d + 1) - 3);
      rd(pa(PAGE_A, OFF_TIME), r);
      chk("counter width", r >> 16, 32'h0);
      chk("block ticks", ticks(c0, r), 32'h4);
    end
    wr(pa(PAGE_A, OFF_CTRL), ctl(1, 1, 0, 0, 0, 0, 0));
    rd(pa(PAGE_A, OFF_TIME), c0);
    t = {16'h0, c0[15:0] + 16'h28};
    d = $urandom_range(14, 1);
    wr(pa(PAGE_A, OFF_TIME), 32'(t));
    wr(pa(PAGE_A, OFF_DATA), 32'(d));
    rdc("pending", pa(PAGE_A, OFF_STATUS), 32'h3);
    // Until its time the port still shows the pulled-up levels it last sampled.
    chk("pins before time", 32'(pin_out), 32'hf);
    poll(pa(PAGE_A, OFF_STATUS), 32'h3, 32'h0);
    chk("pins out", 32'(pin_out), 32'(d));
    chk("all out", 32'(pin_oe), 32'hf);
    rdc("stamp", pa(PAGE_A, OFF_TSTAMP), 32'(t));
    wr(pa(PAGE_A, OFF_DATA), 32'hf);
    wr(pa(PAGE_B, OFF_CTRL), ctl(1, 1, 1, 0, 0, 0, 0));
    for (int v = 0; v < 2; v++)
    begin
      wr(pa(PAGE_B, OFF_DATA), 32'(v));
      poll(pa(PAGE_B, OFF_STATUS), 32'h1, 32'h0);
      @(negedge ref_clk);
      chk("shared out", 32'(pin_out), 32'he);
      chk("shared oe", 32'(pin_oe), 32'({3'h7, v == 0}));
      chk("pin level", 32'(pin_in[0]), 32'(v));
      @(posedge ref_clk);
    end
    wr(pa(PAGE_C, OFF_CTRL), ctl(1, 1, 0, 0, 0, 0, 0));
    wr(pa(PAGE_C, OFF_DATA), 32'h0);
    poll(pa(PAGE_C, OFF_STATUS), 32'h1, 32'h0);
    @(negedge ref_clk);
    chk("narrow c pin", 32'({pin_oe[1], pin_out[1]}), 32'h2);
    @(posedge ref_clk);
    wr(pa(PAGE_C, OFF_CTRL), 32'h0);
    rdc("wide data", pa(PAGE_A, OFF_DATA), 32'hf);
    for (int k = 0; k < 4; k++)
    begin
      d = $urandom_range(3, 0);
      link_en <= 1'b1;
      link_tx <= d[0];
      app_oe <= 4'h8;
      app_val <= {d[1], 3'h0};
      @(negedge ref_clk);
      chk("link oe", 32'(pin_oe[3:2]), 32'h1);
      chk("link tx", 32'(pin_out[2]), 32'(d[0]));
      chk("link rx", 32'(link_rx), 32'(d[1]));
      @(posedge ref_clk);
    end
    link_en <= 1'b0;
    wr(pa(PAGE_A, OFF_CTRL), 32'h0);
    wr(pa(PAGE_B, OFF_COND), 32'h1);
    for (int c = 0; c < 3; c++)
      for (int lvl = 0; lvl < 2; lvl++)
      begin
        app_oe <= 4'hf;
        app_val <= 4'(lvl);
        wr(pa(PAGE_B, OFF_CTRL), ctl(1, 0, 0, 0, c, 0, 0));
        idle(10);
        rdc("cond", pa(PAGE_B, OFF_STATUS), 32'(cond_ok(c, lvl)));
        if (cond_ok(c, lvl))
          rdc("sampled", pa(PAGE_B, OFF_DATA), 32'(lvl));
      end
    wr(pa(PAGE_B, OFF_CTRL), 32'h0);
    d = $urandom_range(15, 0);
    app_val <= 4'(d);
    wr(pa(PAGE_A, OFF_CTRL), ctl(1, 0, 0, 0, 0, 0, 0));
    poll(pa(PAGE_A, OFF_STATUS), 32'h1, 32'h1);
    rdc("wide input", pa(PAGE_A, OFF_DATA), 32'(d));
    chk("input oe", 32'(pin_oe[1:0]), 32'h0);
    app_oe <= 4'h0;
    strobe_lag <= 4'($urandom_range(3, 0));
    d = $urandom_range(14, 0);
    wr(pa(PAGE_A, OFF_CTRL), ctl(1, 1, 0, 0, 0, 1, 1));
    wr(pa(PAGE_A, OFF_DATA), 32'(d));
    idle(6);
    rdc("held for strobe", pa(PAGE_A, OFF_STATUS), 32'h1);
    strobe_req <= 1'b1;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
      if (n > 50)
        give_up();
    end
    while (strobe_output !== 1'b1);
    chk("strobed data", 32'(pin_out), 32'(d));
    @(posedge ref_clk);
    strobe_req <= 1'b0;
    app_oe <= 4'h2;
    app_val <= 4'h0;
    for (int dv = 0; dv < 2; dv++)
    begin
      wr(32'h84, 32'h100 | 32'(dv));
      wr(pa(PAGE_A, OFF_CTRL), ctl(1, 0, 0, 1, 0, 0, 0));
      rd(pa(PAGE_A, OFF_TIME), c0);
      repeat (8)
      begin
        app_val <= 4'h2;
        idle(2);
        app_val <= 4'h0;
        idle(2);
      end
      rd(pa(PAGE_A, OFF_TIME), r);
      chk("pin clock ticks", ticks(c0, r), 32'(8 >> dv));
    end
    tally_and_finish();
  end
endmodule
